// ### bpf_consts.svh
`ifndef BPF_CONSTS_SVH
`define BPF_CONSTS_SVH

// register byte offsets
`define BPF_OFF_CFG      8'h00
`define BPF_OFF_FMAX     8'h04
`define BPF_OFF_LRV      8'h08
`define BPF_OFF_URV      8'h0c
`define BPF_OFF_DAMP     8'h10
`define BPF_OFF_STATUS   8'h14
`define BPF_OFF_FREQ     8'h18
`define BPF_OFF_VALUE    8'h1c
`define BPF_OFF_TEXT     8'h20
`define BPF_OFF_TEXT_END 8'h3c

// reset values: enable on, static, active high
`define BPF_CFG_RESET    9'h005
`define BPF_FMAX_RESET   32'h0001_86a0
`define BPF_LRV_RESET    32'h0000_0000
`define BPF_URV_RESET    32'h0000_0000
`define BPF_DAMP_RESET   6'h00

// limits in hundredths; damping and decimals limits are plain counts
`define BPF_FMAX_MIN     32'sd10000
`define BPF_FMAX_MAX     32'sd100000
`define BPF_LRV_MIN      (-32'sd200000)
`define BPF_LRV_MAX      32'sd0
`define BPF_URV_MIN      32'sd0
`define BPF_URV_MAX      32'sd1000000
`define BPF_DAMP_MAX     6'd60
`define BPF_DEC_MAX      2'd3

// timing
`define BPF_CLK_HZ       25000000
`define BPF_GATE_MS      1000
`define BPF_GATE_CYCLES  ((`BPF_CLK_HZ / 1000) * `BPF_GATE_MS)
`define BPF_DIV_STEPS    6'd48

`endif

// ### bpf_pkg.sv
package bpf_pkg;
    typedef enum logic [1:0] {
        BPF_VAR_FREQ  = 2'h0,
        BPF_VAR_PARAM = 2'h1,
        BPF_VAR_FLOW  = 2'h2,
        BPF_VAR_RSVD  = 2'h3
    } bpf_var_type;

    typedef enum logic [1:0] {
        BPF_FN_RANGE = 2'h0,
        BPF_FN_HOLD  = 2'h1,
        BPF_FN_CLEAN = 2'h2,
        BPF_FN_CTRL  = 2'h3
    } bpf_fn_type;

    typedef enum logic [4:0] {
        BPF_ST_IDLE  = 5'h01,
        BPF_ST_SCALE = 5'h02,
        BPF_ST_AVG   = 5'h04,
        BPF_ST_FMT   = 5'h08,
        BPF_ST_DONE  = 5'h10
    } bpf_state_type;

    typedef struct packed {
        logic [1:0]  decimals;
        bpf_fn_type  fn;
        bpf_var_type var_sel;
        logic        pol_high;
        logic        pfm;
        logic        en;
    } bpf_cfg_type;

    typedef struct packed {
        logic range_sw;
        logic ext_hold;
        logic clean_start;
        logic ctrl_act;
    } bpf_act_type;
endpackage : bpf_pkg

// ### bpf_top.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`include "bpf_consts.svh"

module bpf_top #(
    parameter int GATE_CYCLES = `BPF_GATE_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               ce,
    input  wire logic               reset_n,
    input  wire logic               pin_in,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output bpf_pkg::bpf_act_type    acts,
    output logic signed [31:0]      value_out,
    output logic                    value_strobe
);
    import bpf_pkg::*;

    logic               rst_s1;
    logic               rst_n;
    bpf_cfg_type        cfg;
    logic signed [31:0] fmax;
    logic signed [31:0] lrv;
    logic signed [31:0] urv;
    logic [5:0]         damp;
    logic [31:0]        text_mem [0:7];
    logic [7:0]         aw_addr;
    logic               aw_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               w_held;
    logic               pin_s1;
    logic               pin_s2;
    logic               pin_s3;
    logic               level;
    logic               level_d;
    logic               active;
    logic               active_d;
    logic [31:0]        gate_cnt;
    logic [15:0]        edge_cnt;
    logic [31:0]        freq_m;
    logic               sample_go;
    bpf_state_type      state;
    logic [47:0]        div_rem;
    logic [47:0]        div_quo;
    logic [47:0]        div_dvs;
    logic [5:0]         div_cnt;
    logic               neg;
    logic               fmt_run;
    logic signed [31:0] scaled;
    logic signed [31:0] hist [0:59];
    logic [5:0]         ptr;
    logic [5:0]         fill;
    logic signed [31:0] sum;
    logic signed [31:0] averaged;
    logic signed [31:0] next_sum;
    logic [5:0]         next_fill;
    logic               wr_go;
    logic [31:0]        wr_val;
    logic [31:0]        rd_val;
    logic               rd_ok;
    logic [47:0]        rem_sh;

    // reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // write channel: address and data taken in either order
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            w_held        <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else if (ce) begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready  <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= `BPF_OFF_TEXT_END &&
                                 aw_addr != `BPF_OFF_STATUS && aw_addr != `BPF_OFF_FREQ &&
                                 aw_addr != `BPF_OFF_VALUE) ? 2'h0 : 2'h2;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // settings registers
    always_comb begin
        wr_val = 32'h0000_0000;
        case (aw_addr)
            `BPF_OFF_CFG:  wr_val = merge({23'h000000, cfg}, w_data, w_strb);
            `BPF_OFF_FMAX: wr_val = merge(fmax, w_data, w_strb);
            `BPF_OFF_LRV:  wr_val = merge(lrv, w_data, w_strb);
            `BPF_OFF_URV:  wr_val = merge(urv, w_data, w_strb);
            `BPF_OFF_DAMP: wr_val = merge({26'h0000000, damp}, w_data, w_strb);
            default:       wr_val = merge(text_mem[aw_addr[4:2]], w_data, w_strb);
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg  <= `BPF_CFG_RESET;
            fmax <= `BPF_FMAX_RESET;
            lrv  <= `BPF_LRV_RESET;
            urv  <= `BPF_URV_RESET;
            damp <= `BPF_DAMP_RESET;
        end else if (ce && wr_go) begin
            case (aw_addr)
                `BPF_OFF_CFG:  cfg  <= wr_val[8:0];
                `BPF_OFF_FMAX: fmax <= clamp(wr_val, `BPF_FMAX_MIN, `BPF_FMAX_MAX);
                `BPF_OFF_LRV:  lrv  <= clamp(wr_val, `BPF_LRV_MIN, `BPF_LRV_MAX);
                `BPF_OFF_URV:  urv  <= clamp(wr_val, `BPF_URV_MIN, `BPF_URV_MAX);
                `BPF_OFF_DAMP: damp <= (wr_val[31:6] != 26'h0 || wr_val[5:0] > `BPF_DAMP_MAX) ?
                                       `BPF_DAMP_MAX : wr_val[5:0];
                default: ;
            endcase
        end
    end

    // name and unit text, four words each
    always_ff @(posedge clk) begin
        if (ce && wr_go && aw_addr >= `BPF_OFF_TEXT && aw_addr <= `BPF_OFF_TEXT_END &&
            aw_addr[1:0] == 2'h0) begin
            text_mem[aw_addr[4:2]] <= wr_val;
        end
    end

    // read channel
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `BPF_OFF_CFG:    rd_val = {23'h000000, cfg};
            `BPF_OFF_FMAX:   rd_val = fmax;
            `BPF_OFF_LRV:    rd_val = lrv;
            `BPF_OFF_URV:    rd_val = urv;
            `BPF_OFF_DAMP:   rd_val = {26'h0000000, damp};
            `BPF_OFF_STATUS: rd_val = {29'h00000000, state == BPF_ST_IDLE, active, level};
            `BPF_OFF_FREQ:   rd_val = freq_m;
            `BPF_OFF_VALUE:  rd_val = value_out;
            default: begin
                if (s_axi_araddr >= `BPF_OFF_TEXT && s_axi_araddr <= `BPF_OFF_TEXT_END &&
                    s_axi_araddr[1:0] == 2'h0) begin
                    rd_val = text_mem[s_axi_araddr[4:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // pin synchroniser; level moves once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1  <= 1'b0;
            pin_s2  <= 1'b0;
            pin_s3  <= 1'b0;
            level   <= 1'b0;
            level_d <= 1'b0;
        end else if (ce) begin
            pin_s1  <= pin_in;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            level_d <= level;
            if (pin_s2 == pin_s3) begin
                level <= pin_s3;
            end
        end
    end

    // static level: polarity and routed actions
    assign active = cfg.en && !cfg.pfm && (level == cfg.pol_high);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_d <= 1'b0;
            acts     <= '0;
        end else if (ce) begin
            active_d         <= active;
            acts.range_sw    <= active && cfg.fn == BPF_FN_RANGE;
            acts.ext_hold    <= active && cfg.fn == BPF_FN_HOLD;
            acts.clean_start <= active && !active_d && cfg.fn == BPF_FN_CLEAN;
            acts.ctrl_act    <= active && cfg.fn == BPF_FN_CTRL;
        end
    end

    // pulse counting over a one-second gate, result in millihertz
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_cnt  <= 32'h0000_0000;
            edge_cnt  <= 16'h0000;
            freq_m    <= 32'h0000_0000;
            sample_go <= 1'b0;
        end else if (ce) begin
            sample_go <= 1'b0;
            if (!cfg.en || !cfg.pfm) begin
                gate_cnt <= 32'h0000_0000;
                edge_cnt <= 16'h0000;
                freq_m   <= 32'h0000_0000;
            end else if (gate_cnt == 32'(GATE_CYCLES - 1)) begin
                gate_cnt  <= 32'h0000_0000;
                edge_cnt  <= 16'h0000;
                sample_go <= 1'b1;
                // saturate at the configured maximum
                freq_m <= ((32'(edge_cnt) * 32'd100) > 32'(fmax)) ? 32'(fmax) * 32'd10 :
                          32'(edge_cnt) * 32'd1000;
            end else begin
                gate_cnt <= gate_cnt + 32'h0000_0001;
                if (level && !level_d && edge_cnt != 16'hffff) begin
                    edge_cnt <= edge_cnt + 16'h0001;
                end
            end
        end
    end

    // running sum for the moving average
    always_comb begin
        next_sum  = sum + scaled;
        next_fill = fill;
        if (fill == damp) begin
            next_sum = next_sum - hist[ptr];
        end else begin
            next_fill = fill + 6'h01;
        end
    end

    assign rem_sh = {div_rem[46:0], div_quo[47]};

    // scale, average and format share one serial divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= BPF_ST_IDLE;
            div_rem      <= 48'h0;
            div_quo      <= 48'h0;
            div_dvs      <= 48'h0;
            div_cnt      <= 6'h00;
            neg          <= 1'b0;
            fmt_run      <= 1'b0;
            scaled       <= 32'sh0;
            averaged     <= 32'sh0;
            ptr          <= 6'h00;
            fill         <= 6'h00;
            sum          <= 32'sh0;
            value_out    <= 32'sh0;
            value_strobe <= 1'b0;
        end else if (ce) begin
            value_strobe <= 1'b0;
            if (wr_go && aw_addr == `BPF_OFF_DAMP) begin
                fill <= 6'h00;
                ptr  <= 6'h00;
                sum  <= 32'sh0;
            end
            if (div_cnt != 6'h00) begin
                div_cnt <= div_cnt - 6'h01;
                div_quo <= {div_quo[46:0], rem_sh >= div_dvs};
                div_rem <= (rem_sh >= div_dvs) ? rem_sh - div_dvs : rem_sh;
            end else begin
                case (state)
                    BPF_ST_IDLE: begin
                        if (sample_go) begin
                            div_rem <= 48'h0;
                            div_cnt <= `BPF_DIV_STEPS;
                            if (cfg.var_sel == BPF_VAR_FREQ) begin
                                div_quo <= 48'(freq_m);
                                div_dvs <= 48'h1;
                            end else begin
                                div_quo <= 48'(freq_m) * 48'(urv - lrv);
                                // mhz over hundredths of hz leaves thousandths of the span
                                div_dvs <= 48'(fmax);
                            end
                            state <= BPF_ST_SCALE;
                        end
                    end
                    BPF_ST_SCALE: begin
                        scaled <= (cfg.var_sel == BPF_VAR_FREQ) ? 32'(div_quo) :
                                  lrv * 32'sd10 + 32'(div_quo);
                        state  <= BPF_ST_AVG;
                    end
                    BPF_ST_AVG: begin
                        if (damp == 6'h00) begin
                            averaged <= scaled;
                            state    <= BPF_ST_FMT;
                            neg      <= scaled < 0;
                            div_quo  <= 48'(scaled < 0 ? -scaled : scaled);
                        end else begin
                            hist[ptr] <= scaled;
                            sum       <= next_sum;
                            fill      <= next_fill;
                            ptr       <= (ptr == damp - 6'h01) ? 6'h00 : ptr + 6'h01;
                            neg       <= next_sum < 0;
                            div_quo   <= 48'(next_sum < 0 ? -next_sum : next_sum);
                            div_dvs   <= 48'(next_fill);
                            div_rem   <= 48'h0;
                            div_cnt   <= `BPF_DIV_STEPS;
                            state     <= BPF_ST_DONE;
                        end
                    end
                    BPF_ST_DONE: begin
                        averaged <= neg ? -32'(div_quo) : 32'(div_quo);
                        state    <= BPF_ST_FMT;
                    end
                    BPF_ST_FMT: begin
                        // second visit: quotient holds the value cut to the chosen decimals
                        if (fmt_run) begin
                            value_out    <= neg ? -32'(div_quo) : 32'(div_quo);
                            value_strobe <= 1'b1;
                            fmt_run      <= 1'b0;
                            state        <= BPF_ST_IDLE;
                        end else begin
                            neg     <= averaged < 0;
                            div_quo <= 48'(averaged < 0 ? -averaged : averaged);
                            div_rem <= 48'h0;
                            div_cnt <= `BPF_DIV_STEPS;
                            div_dvs <= (cfg.decimals == `BPF_DEC_MAX) ? 48'd1 :
                                       (cfg.decimals == 2'd2) ? 48'd10 :
                                       (cfg.decimals == 2'd1) ? 48'd100 : 48'd1000;
                            fmt_run <= 1'b1;
                        end
                    end
                    default: state <= BPF_ST_IDLE;
                endcase
            end
        end
    end
endmodule : bpf_top

// ### bpf_checker.sv
module bpf_checker (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 pin_in,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 value_strobe,
    input wire bpf_pkg::bpf_act_type acts
);
    import bpf_pkg::*;
    logic [3:0] pin_age;
    logic [3:0] wr_age;
    // cycles since the pin last moved or a write address was last accepted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pin_age <= 4'h0;
        else if ($changed(pin_in)) pin_age <= 4'h0;
        else if (pin_age != 4'hf) pin_age <= pin_age + 4'h1;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) wr_age <= 4'h0;
        else if (s_axi_awvalid && s_axi_awready) wr_age <= 4'h0;
        else if (wr_age != 4'hf) wr_age <= wr_age + 4'h1;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_awready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted");
    a_acts_onehot: assert property ($onehot0(acts))
        else $error("two action outputs high");
    a_clean_pulse: assert property (acts.clean_start |=> !acts.clean_start)
        else $error("cleaning trigger longer than one cycle");
    a_acts_cause: assert property ($changed(acts) |-> pin_age < 4'ha || wr_age < 4'ha)
        else $error("action output moved without cause");
    c_clean: cover property (acts.clean_start);
    c_range: cover property (acts.range_sw);
    c_value: cover property (value_strobe);
endmodule : bpf_checker

bind bpf_top bpf_checker chk_u (.*);

// ### bpf_pulse_src.sv
module bpf_pulse_src (
    output logic            pin,
    input wire logic        level,
    input wire logic [31:0] half_ns
);
    timeunit 1ns;
    timeprecision 1ns;
    // switch level while half_ns is zero, else a square wave
    initial begin
        pin = 1'b0;
        forever begin
            if (half_ns == 32'h0) begin
                pin = level;
                #5;
            end else begin
                #(half_ns) pin = ~pin;
            end
        end
    end
endmodule : bpf_pulse_src

// ### tb_binary_pulse_freq_input.sv
`include "bpf_consts.svh"
module tb_binary_pulse_freq_input;
    timeunit 1ns;
    timeprecision 1ns;
    import bpf_pkg::*;
    logic        clk, ce, reset_n, pin_in, level, value_strobe;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_wdata, s_axi_rdata, half_ns, rdv;
    logic signed [31:0] value_out;
    bpf_act_type acts;
    int          num_errors, n_tests, seed, n_clean;
    localparam logic [31:0] RST_V [5] = '{32'h5, 32'h186a0, 32'h0, 32'h0, 32'h0};
    bpf_top #(.GATE_CYCLES(1000)) dut_u (.*);
    bpf_pulse_src src_u (.pin(pin_in), .level(level), .half_ns(half_ns));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (acts.clean_start) n_clean++;
    end
    initial begin
        #3000000;
        num_errors++;
        close_out();
    end
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        int dd;
        dd = $signed(got - exp);
        if (dd < 0) dd = -dd;
        n_tests++;
        if ((^got === 1'bx) || dd > tol) begin
            num_errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (s_axi_awready) ta = 1'b1;
            if (s_axi_wready) tw = 1'b1;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        wr(a, d);
        rd(a);
        chk(rdv, e, 0);
    endtask : wrchk
    task automatic measure(input int n, input logic [31:0] e, input int tol);
        int ns;
        ns = 0;
        repeat (n) begin
            @(posedge clk);
            ns += value_strobe;
        end
        chk(ns, n / 1000, 1);
        rd(`BPF_OFF_VALUE);
        chk(rdv, e, tol);
        chk(value_out, e, tol);
    endtask : measure
    // range -10.00..1000.00 over 0..100 Hz, value in thousandths before format
    function automatic logic [31:0] expv(int v, int d, longint fc);
        longint x;
        if (fc > 100000) fc = 100000;
        x = (v == 0) ? fc : -10000 + 1010000 * fc / 100000;
        return 32'(x / (10 ** (3 - d)));
    endfunction : expv
    initial begin
        seed = 95642;
        num_errors = 0;
        n_tests = 0;
        n_clean = 0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        reset_n = 1'b0;
        level = 1'b0;
        half_ns = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4));
            chk(rdv, RST_V[i], 0);
        end
        $display("test reset_values done");
        rd(8'h40);
        chk(rsp, 32'h2, 0);
        wr(`BPF_OFF_VALUE, 32'h1);
        chk(rsp, 32'h2, 0);
        wrchk(`BPF_OFF_FMAX, 32'd5000, 32'd10000);
        wrchk(`BPF_OFF_LRV, -32'sd300000, -32'sd200000);
        wrchk(`BPF_OFF_URV, 32'd2000000, 32'd1000000);
        wrchk(`BPF_OFF_DAMP, 32'd70, 32'd60);
        rdv = $random(seed);
        wrchk(8'h20, rdv, rdv);
        rdv = $random(seed);
        wrchk(8'h3c, rdv, rdv);
        $display("test bus done");
        for (int i = 0; i < 8; i++) begin
            level <= ~i[0];
            wr(`BPF_OFF_CFG, {25'h0, 2'(i[2:1]), 2'h0, i[0], 2'h1});
            repeat (12) @(posedge clk);
            level <= i[0];
            repeat (12) @(posedge clk);
            chk(acts, i[2:1] == 0 ? 8 : i[2:1] == 1 ? 4 : i[2:1] == 3 ? 1 : 0, 0);
        end
        chk(n_clean, 32'd2, 0);
        level <= 1'b0;
        wr(`BPF_OFF_CFG, 32'h4);
        level <= 1'b1;
        repeat (12) @(posedge clk);
        chk(acts, 32'h0, 0);
        $display("test static done");
        wr(`BPF_OFF_FMAX, 32'd10000);
        wr(`BPF_OFF_LRV, -32'sd1000);
        wr(`BPF_OFF_URV, 32'd100000);
        wr(`BPF_OFF_DAMP, 32'h0);
        half_ns <= 32'd150;
        for (int k = 0; k < 7; k++) begin
            wr(`BPF_OFF_CFG, {23'h0, 2'(k < 3 ? 2 : k - 3), 2'h0, 2'(k < 3 ? k : 1), 3'h7});
            measure(2600, expv(k < 3 ? k : 1, k < 3 ? 2 : k - 3, 133000), 0);
        end
        half_ns <= 32'd1000;
        wr(`BPF_OFF_CFG, 32'h10f);
        measure(2600, expv(1, 2, 20000), 1100);
        rd(`BPF_OFF_FREQ);
        chk(rdv, 32'd20000, 1000);
        half_ns <= 32'd150;
        wr(`BPF_OFF_DAMP, 32'd3);
        measure(5000, expv(1, 2, 133000), 0);
        $display("test pulse_freq done");
        close_out();
    end
endmodule : tb_binary_pulse_freq_input
